// ==== hw/sbo_defines.svh ====
// Purpose: Constants for the storage barrier ordering block.
// Assumes: Included by its bare name from the top module and the bench files.
// Notes:   Offsets, fields, resets and timing counts live here.
//
// How it works
// - Older accesses perform before younger ones, per set
// - Heavyweight completes after older work, blocks younger issue
// - Completion needs only appearance, not storage performance
// - Variant 0 heavy, 1 light, 2 page-table
// - Heavyweight orders every access, any attribute
// - Foreign-partition barriers are ignored
// - Heavyweight blocks combining for inhibited/write-through
// - Heavyweight is cumulative, broadcast to all elements
// - Lightweight orders coherence-required accesses like heavyweight
// - Lightweight ignores inhibited or write-through accesses
// - Lightweight is local only, not cumulative
// - I/O barrier waits for older accesses completed
// - I/O barrier orders two sets independently; here an access in either set waits for both sets to drain
// - I/O barrier blocks combining for inhibited/write-through
// - I/O barrier cumulative only for plain coherent storage
// - Inhibited guarded stores always in program order
// - I/O barrier also stalls the other thread
// - Differing attribute classes stay unordered
// - Accesses keep their side of the barrier
// - Fetch barrier stalls both threads, flushes issuer
`ifndef SBO_DEFINES_SVH
`define SBO_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SBO_OFF_CTRL    12'h000
`define SBO_OFF_PART    12'h004
`define SBO_OFF_STATUS  12'h008
`define SBO_OFF_COUNT   12'h00c

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define SBO_CTRL_EN_BIT     0
`define SBO_CTRL_SERL_BIT   1
`define SBO_CTRL_RESET      32'h0000_0003
`define SBO_PART_RESET      8'h00

// ----------------------------------------------------------------
// Barrier variant codes
// ----------------------------------------------------------------
`define SBO_VAR_HEAVY   2'h0
`define SBO_VAR_LIGHT   2'h1
`define SBO_VAR_PTE     2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SBO_CLK_NS      50
`define SBO_DRAIN_NS    100
`define SBO_DRAIN_CYC   ((`SBO_DRAIN_NS + `SBO_CLK_NS - 1) / `SBO_CLK_NS)

`endif

// ==== hw/sbo_pkg.sv ====
// Purpose: Types shared by the storage barrier ordering block.
// Assumes: Nothing beyond the defines header.
// Notes:   Holds only types.
package sbo_pkg;
    // Kind of barrier instruction presented by the pipeline
    typedef enum logic [1:0] {
        SBO_BK_NONE,
        SBO_BK_SYNC,
        SBO_BK_IO,
        SBO_BK_FETCH
    } sbo_kind_e;

    // Storage attributes carried by each pending access
    typedef struct packed {
        logic inh;   // Caching-inhibited
        logic wt;    // Write-through-required
        logic grd;   // Guarded
        logic coh;   // Coherence-required
    } sbo_attr_s;

    // Barrier engine states
    typedef enum logic [1:0] {
        SBO_ST_IDLE,
        SBO_ST_DRAIN,
        SBO_ST_BCAST,
        SBO_ST_DONE
    } sbo_state_e;
endpackage

// ==== hw/sbo_cls_if.sv ====
// Purpose: Carries an access's attributes and its ordering classes.
// Assumes: Used between the top and its classifier.
// Notes:   Purely combinational signal bundle.
`timescale 1ns/100ps
`default_nettype none
interface sbo_cls_if;
    import sbo_pkg::*;
    sbo_attr_s attr;      // Attributes of the access
    logic      is_store;  // Access is a store
    logic      set_io;    // Member of the first I/O set
    logic      set_coh;   // Member of the second I/O set
    logic      lw_ord;    // Ordered by the lightweight barrier
    logic      nocomb;    // Combining forbidden across barrier
    modport src (output attr, output is_store,
                 input set_io, input set_coh, input lw_ord, input nocomb);
    modport cls (input attr, input is_store,
                 output set_io, output set_coh, output lw_ord, output nocomb);
endinterface
`default_nettype wire

// ==== hw/sbo_classify.sv ====
// Purpose: Sorts one access into its barrier ordering sets.
// Assumes: Attributes are tagged on the access by the pipeline.
// Notes:   Combinational; one instance derives every class of the presented access.
`timescale 1ns/100ps
`default_nettype none
module sbo_classify
    import sbo_pkg::*;
(
    sbo_cls_if.cls c
);
    // ------------------------------------------------------------
    // Set decode
    // ------------------------------------------------------------
    // Guarded inhibited loads/stores plus write-through stores share one set
    assign c.set_io  = (c.attr.inh & c.attr.grd) | (c.attr.wt & c.is_store);
    // Plain coherent stores form the second set
    assign c.set_coh = c.attr.coh & ~c.attr.inh & ~c.attr.wt & c.is_store;
    // Lightweight orders coherent accesses that are neither inhibited nor WT
    assign c.lw_ord  = c.attr.coh & ~c.attr.inh & ~c.attr.wt;
    // Combining forbidden for inhibited loads, inhibited or WT stores
    assign c.nocomb  = c.attr.inh | (c.attr.wt & c.is_store);
endmodule
`default_nettype wire

// ==== hw/sbo_top.sv ====
// Purpose: Storage barrier ordering for a two-thread control processor core.
// Assumes: Pipeline presents barriers and access issue requests per thread;
//          storage side reports outstanding counts per class.
// Notes:   Registers over APB; one core clock, asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
`include "sbo_defines.svh"
module sbo_top
    import sbo_pkg::*;
#(
    parameter int PART_W = 8              // Partition id width
)(
    input  wire logic              CORE_CLK_I,     // Core clock
    input  wire logic              ARST_N_I,       // Async reset, low
    // APB slave
    input  wire logic              PSEL_I,         // Select
    input  wire logic              PENABLE_I,      // Access phase
    input  wire logic              PWRITE_I,       // Write
    input  wire logic [11:0]       PADDR_I,        // Byte address
    input  wire logic [31:0]       PWDATA_I,       // Write data
    output logic                   PREADY_O,       // Ready
    output logic [31:0]            PRDATA_O,       // Read data
    output logic                   PSLVERR_O,      // Error
    // Barrier request from the pipeline
    input  wire logic              BAR_VALID_I,    // Barrier presented
    input  wire logic              BAR_TID_I,      // Issuing thread
    input  wire logic [1:0]        BAR_KIND_I,     // sbo_kind_e code
    input  wire logic [1:0]        BAR_VAR_I,      // Variant field
    output logic                   BAR_DONE_O,     // Barrier completed
    // Younger access asking to issue
    input  wire logic              ACC_VALID_I,    // Access wants to go
    input  wire logic              ACC_TID_I,      // Thread of access
    input  wire logic              ACC_STORE_I,    // Store, else load
    input  wire logic [3:0]        ACC_ATTR_I,     // inh,wt,grd,coh
    output logic                   ACC_GO_O,       // Access may issue
    output logic                   ACC_NOCOMB_O,   // Do not combine it
    // Outstanding older accesses, per thread and class
    input  wire logic [1:0]        PEND_IO_I,      // Set one busy
    input  wire logic [1:0]        PEND_COH_I,     // Set two busy
    input  wire logic [1:0]        PEND_ANY_I,     // Any access busy
    input  wire logic [1:0]        PEND_CIG_ST_I,  // Inhibited guarded store busy
    input  wire logic [1:0]        INSTR_BUSY_I,   // Older instructions unfinished
    // System bus broadcast for cumulative barriers
    output logic                   BC_VALID_O,     // Broadcast request
    output logic [PART_W-1:0]      BC_PART_O,      // Partition of issuer
    output logic                   BC_COH_ONLY_O,  // Cumulative for coherent only
    input  wire logic              BC_ACK_I,       // Bus acknowledged
    // Barrier snooped from other elements
    input  wire logic              SNP_VALID_I,    // Remote barrier seen
    input  wire logic [PART_W-1:0] SNP_PART_I,     // Remote partition
    output logic                   SNP_HONOR_O,    // Remote barrier honoured
    // Issue control to the pipeline
    output logic [1:0]             ISSUE_STALL_O,  // Per-thread issue stall
    output logic                   FLUSH_O,        // Discard prefetch
    output logic                   FLUSH_TID_O     // Thread to flush
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    sbo_state_e          st_r;          // Engine state
    sbo_state_e          st_nxt;        // Next state
    sbo_kind_e           kind_r;        // Kind being held
    logic [1:0]          var_r;         // Variant being held
    logic                tid_r;         // Issuing thread held
    logic                en_r;          // Block enable
    logic                serl_r;        // Serialise other thread on I/O
    logic [PART_W-1:0]   part_r;        // Own partition
    logic [15:0]         cnt_r;         // Barriers completed
    logic [7:0]          drain_r;       // Drain settle counter
    logic                drained;       // Older work has appeared done
    logic                need_bc;       // Barrier needs broadcast
    logic                apb_wr;        // APB write strobe
    logic                apb_rd;        // APB read strobe
    logic                addr_ok;       // Mapped address
    logic                busy;          // Barrier in flight
    logic                fl_r;          // Flush pulse
    logic                blk_acc;       // Access held back
    sbo_kind_e           bkind;         // Decoded kind input
    // Reset image of the control register, split into its bits below
    localparam logic [31:0] ctrl_rst = `SBO_CTRL_RESET;

    sbo_cls_if cif ();                  // Classification of the access

    // ------------------------------------------------------------
    // Access classification
    // ------------------------------------------------------------
    // Each access arrives tagged with its four attributes
    assign cif.attr     = ACC_ATTR_I;
    assign cif.is_store = ACC_STORE_I;

    sbo_classify u_cls (
        .c (cif.cls)
    );

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign apb_wr    = PSEL_I & PENABLE_I & PWRITE_I;
    assign apb_rd    = PSEL_I & ~PWRITE_I;
    assign addr_ok   = (PADDR_I == `SBO_OFF_CTRL) | (PADDR_I == `SBO_OFF_PART) |
                       (PADDR_I == `SBO_OFF_STATUS) | (PADDR_I == `SBO_OFF_COUNT);
    // Zero-wait slave: every transfer ends in its first access cycle,
    // so read data must already stand when the access phase begins
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_ok;

    // Control register write
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            en_r   <= ctrl_rst[`SBO_CTRL_EN_BIT];
            serl_r <= ctrl_rst[`SBO_CTRL_SERL_BIT];
        end else if (apb_wr && PADDR_I == `SBO_OFF_CTRL) begin
            en_r   <= PWDATA_I[`SBO_CTRL_EN_BIT];
            serl_r <= PWDATA_I[`SBO_CTRL_SERL_BIT];
        end
    end

    // Partition register write
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            part_r <= PART_W'(`SBO_PART_RESET);
        end else if (apb_wr && PADDR_I == `SBO_OFF_PART) begin
            part_r <= PWDATA_I[PART_W-1:0];
        end
    end

    // Read data register, loaded in the setup cycle
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            PRDATA_O <= 32'h0;
        end else if (apb_rd && !PENABLE_I) begin
            case (PADDR_I)
                `SBO_OFF_CTRL:   PRDATA_O <= {30'h0, serl_r, en_r};
                `SBO_OFF_PART:   PRDATA_O <= 32'(part_r);
                `SBO_OFF_STATUS: PRDATA_O <= {24'h0, ISSUE_STALL_O, var_r,
                                              kind_r, st_r};
                `SBO_OFF_COUNT:  PRDATA_O <= {16'h0, cnt_r};
                default:         PRDATA_O <= 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Barrier engine
    // ------------------------------------------------------------
    assign bkind = sbo_kind_e'(BAR_KIND_I);
    assign busy  = (st_r != SBO_ST_IDLE);

    // Decide when older work appears complete for the held barrier
    // Heavy completion waits only for older instructions to look done;
    // storage may still be performing their accesses at that point
    always_comb begin
        drained = 1'b0;
        case (kind_r)
            SBO_BK_SYNC: begin
                // Heavy needs only appearance of completion, not storage performance; light waits for set two to drain
                if (var_r == `SBO_VAR_LIGHT) begin
                    drained = ~PEND_COH_I[tid_r];
                end else begin
                    drained = ~INSTR_BUSY_I[tid_r];
                end
            end
            // Older main-storage accesses completed in both sets
            SBO_BK_IO:    drained = ~PEND_IO_I[tid_r] & ~PEND_COH_I[tid_r];
            SBO_BK_FETCH: drained = ~INSTR_BUSY_I[0] & ~INSTR_BUSY_I[1];
            default:      drained = 1'b1;
        endcase
    end

    // Only heavyweight, page-table and I/O barriers go out on the bus
    // The light barrier is local to this core, so no other element sees it
    assign need_bc = (kind_r == SBO_BK_IO) ||
                     (kind_r == SBO_BK_SYNC && var_r != `SBO_VAR_LIGHT);

    // Next state
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            SBO_ST_IDLE:  if (BAR_VALID_I && en_r && bkind != SBO_BK_NONE) begin
                st_nxt = SBO_ST_DRAIN;
            end
            SBO_ST_DRAIN: if (drained && drain_r == 8'h0) begin
                st_nxt = need_bc ? SBO_ST_BCAST : SBO_ST_DONE;
            end
            SBO_ST_BCAST: if (BC_ACK_I) begin
                st_nxt = SBO_ST_DONE;
            end
            SBO_ST_DONE:  st_nxt = SBO_ST_IDLE;
            default:      st_nxt = SBO_ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_r <= SBO_ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Capture the barrier on acceptance
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            kind_r <= SBO_BK_NONE;
            var_r  <= `SBO_VAR_HEAVY;
            tid_r  <= 1'b0;
        end else if (st_r == SBO_ST_IDLE && st_nxt == SBO_ST_DRAIN) begin
            kind_r <= bkind;
            var_r  <= BAR_VAR_I;
            tid_r  <= BAR_TID_I;
        end
    end

    // Minimum settle time before the drain may be declared
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            drain_r <= 8'h0;
        end else if (st_r == SBO_ST_IDLE) begin
            drain_r <= 8'(`SBO_DRAIN_CYC - 1);
        end else if (drain_r != 8'h0) begin
            drain_r <= drain_r - 8'h1;
        end
    end

    // Completed barrier count
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cnt_r <= 16'h0;
        end else if (st_r == SBO_ST_DONE) begin
            cnt_r <= cnt_r + 16'h1;
        end
    end

    // Fetch barrier flushes the issuing thread once on acceptance
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            fl_r <= 1'b0;
        end else begin
            fl_r <= (st_r == SBO_ST_IDLE) && (st_nxt == SBO_ST_DRAIN) &&
                    (bkind == SBO_BK_FETCH);
        end
    end

    assign FLUSH_O       = fl_r;
    assign FLUSH_TID_O   = tid_r;
    assign BAR_DONE_O    = (st_r == SBO_ST_DONE);

    // ------------------------------------------------------------
    // Cumulative broadcast and snoop
    // ------------------------------------------------------------
    assign BC_VALID_O    = (st_r == SBO_ST_BCAST);
    assign BC_PART_O     = part_r;
    assign BC_COH_ONLY_O = (kind_r == SBO_BK_IO);
    // Remote barriers from other partitions are dropped
    assign SNP_HONOR_O   = SNP_VALID_I && (SNP_PART_I == part_r);

    // ------------------------------------------------------------
    // Issue gating
    // ------------------------------------------------------------
    // Per-thread stall of new instruction issue
    always_comb begin
        ISSUE_STALL_O = 2'b00;
        if (busy && st_r != SBO_ST_DONE) begin
            case (kind_r)
                SBO_BK_FETCH: ISSUE_STALL_O = 2'b11;
                SBO_BK_SYNC:  if (var_r != `SBO_VAR_LIGHT) begin
                    ISSUE_STALL_O[tid_r] = 1'b1;
                end
                default:      ISSUE_STALL_O = 2'b00;
            endcase
        end
    end

    // Whether the presented younger access must wait
    // An I/O barrier holds the issuer's accesses only inside one of its two sets;
    // that thread's other traffic keeps flowing, while serl_r holds the other thread
    always_comb begin
        blk_acc = 1'b0;
        // Program order for inhibited guarded stores, barrier or not
        if (ACC_STORE_I && cif.attr.inh && cif.attr.grd && PEND_CIG_ST_I[ACC_TID_I]) begin
            blk_acc = 1'b1;
        end
        if (busy && st_r != SBO_ST_DONE) begin
            case (kind_r)
                SBO_BK_SYNC: begin
                    if (var_r == `SBO_VAR_LIGHT) begin
                        // Only own thread, only coherent cacheable accesses
                        blk_acc = blk_acc | ((ACC_TID_I == tid_r) & cif.lw_ord);
                    end else if (ACC_TID_I == tid_r) begin
                        blk_acc = 1'b1;
                    end
                end
                SBO_BK_IO: begin
                    if (ACC_TID_I == tid_r) begin
                        // Only accesses in a set are held; others pass freely
                        blk_acc = blk_acc | cif.set_io | cif.set_coh;
                    end else begin
                        blk_acc = blk_acc | serl_r;
                    end
                end
                SBO_BK_FETCH: blk_acc = 1'b1;
                default:      blk_acc = blk_acc;
            endcase
        end
    end

    assign ACC_GO_O     = ACC_VALID_I & ~blk_acc;
    // Combining forbidden for marked classes near a barrier
    assign ACC_NOCOMB_O = ACC_VALID_I & cif.nocomb & (busy | BAR_VALID_I);

endmodule
`default_nettype wire

// ==== tb/sbo_top_props.sv ====
// Purpose: Port-level checks of the barrier ordering block.
// Assumes: Barrier inputs are held until the done pulse.
// Notes:   Bound into every sbo_top instance.
`timescale 1ns/100ps
`default_nettype none
`include "sbo_defines.svh"
module sbo_top_props
    import sbo_pkg::*;
#(
    parameter int PART_W = 8
)(
    input wire logic              CORE_CLK_I,
    input wire logic              ARST_N_I,
    input wire logic              BAR_VALID_I,
    input wire logic              BAR_TID_I,
    input wire logic [1:0]        BAR_KIND_I,
    input wire logic [1:0]        BAR_VAR_I,
    input wire logic              BAR_DONE_O,
    input wire logic              ACC_VALID_I,
    input wire logic              ACC_TID_I,
    input wire logic              ACC_STORE_I,
    input wire logic [3:0]        ACC_ATTR_I,
    input wire logic              ACC_GO_O,
    input wire logic              ACC_NOCOMB_O,
    input wire logic [1:0]        PEND_COH_I,
    input wire logic              BC_VALID_O,
    input wire logic [PART_W-1:0] BC_PART_O,
    input wire logic              BC_COH_ONLY_O,
    input wire logic              SNP_VALID_I,
    input wire logic [PART_W-1:0] SNP_PART_I,
    input wire logic              SNP_HONOR_O,
    input wire logic [1:0]        ISSUE_STALL_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    logic held_r; // Barrier was shown last cycle
    logic hv;     // Heavyweight or page-table variant
    logic lt;     // Lightweight variant
    logic busy;   // Barrier accepted and not yet done
    // Remember the previous barrier request level
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) held_r <= 1'h0;
        else held_r <= BAR_VALID_I;
    end
    assign hv = BAR_KIND_I == SBO_BK_SYNC && BAR_VAR_I != `SBO_VAR_LIGHT;
    assign lt = BAR_KIND_I == SBO_BK_SYNC && BAR_VAR_I == `SBO_VAR_LIGHT;
    assign busy = BAR_VALID_I && held_r && !BAR_DONE_O;
    a_snoop_part: assert property (
        SNP_HONOR_O == (SNP_VALID_I && SNP_PART_I == BC_PART_O)) else $error("snoop honour");
    a_done_once: assert property (
        BAR_DONE_O |=> !BAR_DONE_O) else $error("done longer than one cycle");
    a_done_late: assert property (
        BAR_DONE_O |-> $past(BAR_VALID_I, 3)) else $error("done too early");
    a_heavy_bcast: assert property (
        BAR_DONE_O && hv |-> $past(BC_VALID_O)) else $error("heavy done without broadcast");
    a_light_local: assert property (
        BAR_VALID_I && lt |-> !BC_VALID_O) else $error("light barrier broadcast");
    a_io_coh_only: assert property (
        BC_VALID_O |-> BC_COH_ONLY_O == (BAR_KIND_I == SBO_BK_IO)) else $error("coh-only flag");
    a_heavy_stall: assert property (
        busy && hv |-> ISSUE_STALL_O[BAR_TID_I]) else $error("issuer not stalled");
    a_fetch_both: assert property (
        busy && BAR_KIND_I == SBO_BK_FETCH |-> ISSUE_STALL_O == 2'h3) else $error("fetch stall");
    a_nocomb_busy: assert property (
        busy && hv && ACC_VALID_I && (ACC_ATTR_I[3] || (ACC_ATTR_I[2] && ACC_STORE_I))
        |-> ACC_NOCOMB_O) else $error("combining allowed");
    a_young_wait: assert property (
        busy && hv && ACC_VALID_I && ACC_TID_I == BAR_TID_I |-> !ACC_GO_O) else $error("young go");
    a_light_drain: assert property (
        BAR_DONE_O && lt |-> !$past(PEND_COH_I[BAR_TID_I])) else $error("light done undrained");
endmodule
bind sbo_top sbo_top_props #(.PART_W(PART_W)) chk_u (.*);
`default_nettype wire

// ==== tb/sbo_stor_model.sv ====
// Purpose: Storage side: outstanding accesses and bus acknowledge.
// Assumes: Older work drains once a barrier is shown.
// Notes:   slow_i lengthens drain and acknowledge.
`timescale 1ns/100ps
`default_nettype none
module sbo_stor_model (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       bar_valid_i,
    input  wire logic       bc_valid_i,
    input  wire logic       slow_i,
    output logic [1:0]      pend_o,
    output logic            ack_o
);
    logic [3:0] age_r; // Cycles since barrier shown
    // Age of the current barrier, saturating
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) age_r <= 4'h0;
        else if (!bar_valid_i) age_r <= 4'h0;
        else if (age_r != 4'hf) age_r <= age_r + 4'h1;
    end
    // Older work stays busy a while; completion must wait on it
    assign pend_o = (age_r < (slow_i ? 4'h6 : 4'h1)) ? 2'h3 : 2'h0;
    // One-cycle bus acknowledge, late when slow
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) ack_o <= 1'h0;
        else ack_o <= bc_valid_i && !ack_o && (!slow_i || age_r > 4'h9);
    end
endmodule
`default_nettype wire

// ==== tb/test_storage_barrier_ordering.sv ====
// Purpose: Self-checking bench for the barrier ordering block.
// Assumes: Zero-wait APB slave; barrier held until done pulse.
// Notes:   Storage side comes from sbo_stor_model.
`timescale 1ns/100ps
`default_nettype none
`include "sbo_defines.svh"
module test_storage_barrier_ordering
    import sbo_pkg::*;
;
    logic        clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0, stv = 1'h1;
    logic        bv = 1'h0, btid = 1'h0, av = 1'h0, atid = 1'h0, sv = 1'h0, slow = 1'h0;
    logic        ack, rdy, err, done, go, nc, bc, bco, hon, fl, flt, e;
    logic [11:0] padr = 12'h0;
    logic [3:0]  attr = 4'h1;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic [1:0]  bk = 2'h0, bvar = 2'h0, pend, stall;
    logic [7:0]  sp = 8'h0, bcp;
    logic [5:0]  tbl [6] = '{6'h10, 6'h17, 6'h18, 6'h20, 6'h22, 6'h33}; // Kind,var,tid,acc
    int          bad_count = 0, num_checks = 0;
    sbo_top #(.PART_W(8)) dut_u (
        .CORE_CLK_I(clk), .ARST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PREADY_O(rdy),
        .PRDATA_O(prd), .PSLVERR_O(err), .BAR_VALID_I(bv), .BAR_TID_I(btid),
        .BAR_KIND_I(bk), .BAR_VAR_I(bvar), .BAR_DONE_O(done), .ACC_VALID_I(av),
        .ACC_TID_I(atid), .ACC_STORE_I(stv), .ACC_ATTR_I(attr), .ACC_GO_O(go),
        .ACC_NOCOMB_O(nc), .PEND_IO_I(pend), .PEND_COH_I(pend), .PEND_ANY_I(pend),
        .PEND_CIG_ST_I(pend), .INSTR_BUSY_I(pend), .BC_VALID_O(bc), .BC_PART_O(bcp),
        .BC_COH_ONLY_O(bco), .BC_ACK_I(ack), .SNP_VALID_I(sv), .SNP_PART_I(sp),
        .SNP_HONOR_O(hon), .ISSUE_STALL_O(stall), .FLUSH_O(fl), .FLUSH_TID_O(flt));
    sbo_stor_model stor_u (.clk_i(clk), .rst_n_i(rst_n), .bar_valid_i(bv),
        .bc_valid_i(bc), .slow_i(slow), .pend_o(pend), .ack_o(ack));
    initial forever #25 clk = ~clk;
    // Compare and count
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask
    // One APB transfer; read data and error land in rd and e
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'h1;
        do @(posedge clk); while (rdy !== 1'h1);
        rd = prd;
        e = err;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask
    // Present a barrier with a younger access, watch until done
    task automatic bar(input logic [1:0] k, input logic [1:0] v, input logic t, input logic a);
        logic sb, ss, sf, sg, sn;
        int   n;
        {sb, ss, sf, sg, sn} = 5'h0;
        n = 0;
        @(posedge clk);
        bv <= 1'h1;
        bk <= k;
        bvar <= v;
        btid <= t;
        av <= 1'h1;
        atid <= a;
        do begin
            @(posedge clk);
            sb |= bc;
            ss |= stall[t];
            sf |= fl & (flt == t);
            sn |= nc;
            if (n > 0 && done !== 1'h1) sg |= go;
            n++;
        end while (done !== 1'h1);
        bv <= 1'h0;
        av <= 1'h0;
        chk("bcast", 32'(k == 2'h2 || (k == 2'h1 && v != 2'h1)), 32'(sb));
        chk("flush", 32'(k == 2'h3), 32'(sf));
        chk("young_go", 32'h0, 32'(sg));
        chk("nocomb", 32'(attr[3]), 32'(sn));
        if (k == 2'h3 || (k == 2'h1 && v != 2'h1)) chk("stall", 32'h1, 32'(ss));
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        apb(1'h0, `SBO_OFF_CTRL, 32'h0);
        chk("ctrl", `SBO_CTRL_RESET, rd);
        apb(1'h1, `SBO_OFF_PART, 32'h5a);
        apb(1'h0, `SBO_OFF_PART, 32'h0);
        chk("part", 32'h5a, rd);
        apb(1'h0, 12'h0f0, 32'h0);
        chk("unmapped", 32'h1, 32'(e));
        @(posedge clk);
        sv <= 1'h1;
        sp <= 8'h5a;
        @(posedge clk);
        chk("honor", 32'h1, 32'(hon));
        sp <= 8'h11;
        @(posedge clk);
        chk("foreign", 32'h0, 32'(hon));
        sv <= 1'h0;
        for (int i = 0; i < 6; i++) begin
            slow <= i[0];
            {attr, stv} <= i[1] ? {4'ha, i[0]} : 5'h3;
            bar(tbl[i][5:4], tbl[i][3:2], tbl[i][1], tbl[i][0]);
        end
        apb(1'h0, `SBO_OFF_COUNT, 32'h0);
        chk("count", 32'h6, rd);
        print_verdict();
    end
    // Watchdog
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
